// [src/cdz_doze_ctrl.sv]
// Reduced-rate (doze) execution control for the processor core
//
// Contract
// - Interrupt with recover bit 0 runs its service routine at reduced rate.
// - Interrupt latency in doze with recover bit 0 grows in proportion to the doze ratio.
// - Interrupt with recover bit 1 clears doze enable, resumes full speed.
// - On recovery, finish prefetched instruction first, then vector.
// - Recovery takes effect at once, even mid doze period.
// - Return from interrupt with reduce-on-return 1 sets doze enable.
// - Sleep instruction enters Sleep if idle bit 0, Idle if 1.
`timescale 1ns/100ps
`default_nettype none
`include "cdz_map.svh"
module cdz_doze_ctrl
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [`CDZ_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // Core sequencer events (one-cycle pulses)
    input wire logic intReq,
    input wire logic retfiExec,
    input wire logic sleepExec,
    // Core control
    output cdz_pkg::cdz_core_t coreCtl
);
    cdz_pkg::cdz_ctrl_t ctrl_q;
    cdz_pkg::cdz_state_t state_q;
    logic [7:0] divCnt_q;
    logic [7:0] lastCnt;
    logic tick;
    logic [7:0] ctrlBits;
    logic [7:0] rdata_q;
    cdz_pkg::cdz_core_t core_q;
    // Reset image of the register, split into its fields below
    localparam logic [7:0] rstCtrl = `CDZ_RST_CTRL;

    // ----------------------------------------
    // Doze ratio divider
    // ----------------------------------------
    // Ratio k gives a period of 2^(k+1) system cycles. The last count is
    // formed by a right shift so that ratio 7 (256 cycles) needs no ninth
    // counter bit.
    assign lastCnt = 8'hff >> (3'h7 - ctrl_q.ratio);
    // Compare with >= so that lowering the ratio mid period cannot strand
    // the counter above its new end and stall the core for 256 cycles
    assign tick = !ctrl_q.dozeEn || (divCnt_q >= lastCnt);
    assign ctrlBits = {ctrl_q.idleSel, ctrl_q.dozeEn, ctrl_q.recoverOnInt,
        ctrl_q.reduceOnReturn, 1'b0, ctrl_q.ratio};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            divCnt_q <= 8'h00;
        else if (tick || (intReq && ctrl_q.recoverOnInt))
            divCnt_q <= 8'h00;
        else
            divCnt_q <= divCnt_q + 8'h01;
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    // Hardware updates of doze enable win over a software write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= {rstCtrl[`CDZ_BIT_IDLE], rstCtrl[`CDZ_BIT_DOZE],
                rstCtrl[`CDZ_BIT_ROI], rstCtrl[`CDZ_BIT_DOE],
                rstCtrl[`CDZ_RATIO_HI:`CDZ_RATIO_LO]};
        else
        begin
            // Bit 3 is unimplemented: fields are picked out one by one so
            // that the 8-bit write lines up with the 7-bit packed register
            if (regWr && regAddr == `CDZ_OFF_CTRL)
                ctrl_q <= {regWdata[`CDZ_BIT_IDLE], regWdata[`CDZ_BIT_DOZE],
                    regWdata[`CDZ_BIT_ROI], regWdata[`CDZ_BIT_DOE],
                    regWdata[`CDZ_RATIO_HI:`CDZ_RATIO_LO]};
            if (intReq && ctrl_q.recoverOnInt)
                ctrl_q.dozeEn <= 1'b0;
            else if (retfiExec && ctrl_q.reduceOnReturn)
                ctrl_q.dozeEn <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= 8'h00;
        else if (regRd && regAddr == `CDZ_OFF_CTRL)
            rdata_q <= ctrlBits;
        else
            rdata_q <= 8'h00;
    end
    assign regRdata = rdata_q;

    // ----------------------------------------
    // Interrupt sequencing
    // ----------------------------------------
    // RUN: normal issue. FINISH: prefetched instruction at full speed.
    // VECTOR: vectoring cycle. Without recovery the vector waits a tick.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= cdz_pkg::ST_RUN;
        else
            case (state_q)
                cdz_pkg::ST_RUN:
                    if (intReq && ctrl_q.recoverOnInt)
                        state_q <= cdz_pkg::ST_FINISH;
                    else if (intReq)
                        state_q <= cdz_pkg::ST_VECTOR;
                cdz_pkg::ST_FINISH:
                    state_q <= cdz_pkg::ST_VECTOR;
                cdz_pkg::ST_VECTOR:
                    if (tick)
                        state_q <= cdz_pkg::ST_RUN;
                default:
                    state_q <= cdz_pkg::ST_RUN;
            endcase
    end

    // ----------------------------------------
    // Core outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            core_q <= '0;
        else
        begin
            core_q.issue <= tick && state_q != cdz_pkg::ST_VECTOR;
            core_q.vector <= state_q == cdz_pkg::ST_VECTOR && tick;
            core_q.sleep <= sleepExec && !ctrl_q.idleSel;
            core_q.idle <= sleepExec && ctrl_q.idleSel;
        end
    end
    assign coreCtl = core_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Clear beats set, so a return in the same cycle must not keep doze on
    a_roi_clears_doze: assert property (@(posedge clk)
        disable iff (!arst_n)
        intReq && ctrl_q.recoverOnInt |=> !ctrl_q.dozeEn)
        else $error("doze enable not cleared on recovery");

    a_return_sets_doze: assert property (@(posedge clk)
        disable iff (!arst_n)
        retfiExec && ctrl_q.reduceOnReturn && !intReq |=> ctrl_q.dozeEn)
        else $error("doze enable not set on return");

    a_finish_then_vec: assert property (@(posedge clk)
        disable iff (!arst_n)
        state_q == cdz_pkg::ST_RUN && intReq && ctrl_q.recoverOnInt
        |=> state_q == cdz_pkg::ST_FINISH ##1 state_q == cdz_pkg::ST_VECTOR
        ##1 core_q.vector)
        else $error("recovery did not finish then vector");

    a_prefetch_issue: assert property (@(posedge clk)
        disable iff (!arst_n)
        state_q == cdz_pkg::ST_FINISH |=> core_q.issue)
        else $error("prefetched instruction not issued");

    a_recover_now: assert property (@(posedge clk)
        disable iff (!arst_n)
        intReq && ctrl_q.recoverOnInt |=> tick)
        else $error("recovery waited for doze period");

    a_recover_restart: assert property (@(posedge clk)
        disable iff (!arst_n)
        intReq && ctrl_q.recoverOnInt |=> divCnt_q == 8'h00)
        else $error("doze divider not restarted on recovery");

    a_sleep_select: assert property (@(posedge clk)
        disable iff (!arst_n)
        sleepExec |=> (core_q.idle == $past(ctrl_q.idleSel))
        && (core_q.sleep != $past(ctrl_q.idleSel)))
        else $error("wrong sleep mode entered");

    a_sleep_on_cmd: assert property (@(posedge clk)
        disable iff (!arst_n)
        !sleepExec |=> !core_q.sleep && !core_q.idle)
        else $error("sleep or idle without a sleep instruction");

    a_period_gap: assert property (@(posedge clk)
        disable iff (!arst_n)
        ctrl_q.dozeEn && ctrl_q.ratio == 3'h0 && tick && !intReq
        ##1 ctrl_q.dozeEn && ctrl_q.ratio == 3'h0 |-> !tick)
        else $error("issue rate too high in doze");

    a_doze_no_burst: assert property (@(posedge clk)
        disable iff (!arst_n)
        ctrl_q.dozeEn && tick && !intReq ##1 ctrl_q.dozeEn |-> !tick)
        else $error("two doze ticks in a row");

    a_full_speed: assert property (@(posedge clk)
        disable iff (!arst_n)
        !ctrl_q.dozeEn && state_q != cdz_pkg::ST_VECTOR |=> core_q.issue)
        else $error("issue slot lost at full speed");

    a_reduced_isr: assert property (@(posedge clk)
        disable iff (!arst_n)
        state_q == cdz_pkg::ST_RUN && intReq && !ctrl_q.recoverOnInt
        |=> state_q == cdz_pkg::ST_VECTOR && $stable(ctrl_q.dozeEn))
        else $error("reduced-rate service not kept");

    a_vector_on_tick: assert property (@(posedge clk)
        disable iff (!arst_n)
        state_q == cdz_pkg::ST_VECTOR && tick |=> core_q.vector)
        else $error("vector not issued on doze tick");

    a_latency_wait: assert property (@(posedge clk)
        disable iff (!arst_n)
        state_q == cdz_pkg::ST_VECTOR && !tick |=> !core_q.vector)
        else $error("vector issued before doze tick");

    a_vector_no_issue: assert property (@(posedge clk)
        disable iff (!arst_n)
        state_q == cdz_pkg::ST_VECTOR |=> !core_q.issue)
        else $error("instruction issued while waiting to vector");

    a_read_idle_zero: assert property (@(posedge clk)
        disable iff (!arst_n)
        !regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside a read");
endmodule // cdz_doze_ctrl
`default_nettype wire

// [src/cdz_map.svh]
// Register offsets, field positions and reset values of the doze control
`ifndef CDZ_MAP_SVH
`define CDZ_MAP_SVH
`define CDZ_ADDR_W 12
`define CDZ_OFF_CTRL 12'h88c
`define CDZ_RST_CTRL 8'h00
`define CDZ_BIT_IDLE 7
`define CDZ_BIT_DOZE 6
`define CDZ_BIT_ROI 5
`define CDZ_BIT_DOE 4
`define CDZ_RATIO_HI 2
`define CDZ_RATIO_LO 0
`define CDZ_CTRL_MASK 8'hf7
`endif

// [src/cdz_pkg.sv]
// Types shared by the doze control block
`default_nettype none
package cdz_pkg;
    typedef struct packed {
        logic idleSel;
        logic dozeEn;
        logic recoverOnInt;
        logic reduceOnReturn;
        logic [2:0] ratio;
    } cdz_ctrl_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FINISH = 2'b01,
        ST_VECTOR = 2'b10
    } cdz_state_t;
    typedef struct packed {
        logic issue;
        logic vector;
        logic sleep;
        logic idle;
    } cdz_core_t;
endpackage
`default_nettype wire

// [dv/cdz_core_model.sv]
// Core sequencer model: event pulses out, issue slots counted
`timescale 1ns/100ps
`default_nettype none
module cdz_core_model
(
    // Clock
    input wire logic clk,
    // Core link
    input wire cdz_pkg::cdz_core_t coreCtl,
    output logic intReq,
    output logic retfiExec,
    output logic sleepExec,
    output int issues
);
    initial {intReq, retfiExec, sleepExec, issues} = '0;
    always @(posedge clk)
        if (coreCtl.issue === 1'b1)
            issues <= issues + 1;
    // One-cycle event: 0 interrupt, 1 return, 2 sleep
    task automatic pulse(input int k);
        intReq <= k == 0;
        retfiExec <= k == 1;
        sleepExec <= k == 2;
        @(posedge clk);
        {intReq, retfiExec, sleepExec} <= 3'b000;
    endtask
endmodule // cdz_core_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the doze control
`timescale 1ns/100ps
`default_nettype none
`include "cdz_map.svh"
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
    logic clk = 0, arst_n = 0, regWr = 0, regRd = 0, rdPend = 0;
    logic [11:0] regAddr = '0;
    logic [7:0] regWdata = '0, regRdata, ex;
    logic intReq, retfiExec, sleepExec;
    cdz_pkg::cdz_core_t coreCtl;
    int failures = 0, n_tests = 0, issues, t0, r;
    logic [7:0] expQ[$];
    initial forever #12.5 clk = ~clk;
    cdz_doze_ctrl dut_u (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .intReq(intReq), .retfiExec(retfiExec),
        .sleepExec(sleepExec), .coreCtl(coreCtl));
    cdz_core_model core_u (.clk(clk), .coreCtl(coreCtl), .intReq(intReq),
        .retfiExec(retfiExec), .sleepExec(sleepExec), .issues(issues));
    // Read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        if (rdPend)
        begin
            ex = expQ.pop_front();
            `CHK("read data", ex, regRdata)
        end
        rdPend <= regRd;
    end
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1;
        @(posedge clk);
        regWr <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 0;
    endtask
    task automatic waitVec(input int lo, input int hi);
        int n;
        n = 0;
        while (coreCtl.vector !== 1'b1 && n <= hi)
        begin
            @(posedge clk);
            n++;
        end
        `CHK("vector delay", 1'b1, n >= lo && n <= hi)
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #500us;
        failures++;
        wrap_up;
    end
    initial
    begin
        r = $urandom(63188);
        repeat (5) @(posedge clk);
        arst_n <= 1;
        rd(`CDZ_OFF_CTRL, `CDZ_RST_CTRL);
        rd(12'h88d, 8'h00);
        wr(`CDZ_OFF_CTRL, 8'hff);
        rd(`CDZ_OFF_CTRL, 8'hf7);
        for (int i = 0; i < 8; i++)
        begin
            r = 8'h40 | i | ($urandom & 8'h90);
            wr(`CDZ_OFF_CTRL, r[7:0]);
            rd(`CDZ_OFF_CTRL, r[7:0]);
            repeat (8 << i) @(posedge clk);
            t0 = issues;
            repeat (32 << i) @(posedge clk);
            `CHK("issue rate", 1'b1, issues - t0 inside {[15:17]})
            core_u.pulse(0);
            waitVec(1, (2 << i) + 2);
        end
        // Interrupt lands mid doze period
        wr(`CDZ_OFF_CTRL, 8'h75);
        repeat (5) @(posedge clk);
        core_u.pulse(0);
        waitVec(3, 3);
        rd(`CDZ_OFF_CTRL, 8'h35);
        core_u.pulse(1);
        rd(`CDZ_OFF_CTRL, 8'h75);
        for (int i = 0; i < 2; i++)
        begin
            wr(`CDZ_OFF_CTRL, {i[0], 7'h00});
            core_u.pulse(2);
            @(posedge clk);
            `CHK("sleep", {~i[0], i[0]}, {coreCtl.sleep, coreCtl.idle})
        end
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
